// ==== common/adc_mon_consts.vh ====
`ifndef ADC_MON_CONSTS_VH
`define ADC_MON_CONSTS_VH

// Serial address, arbitrary value
`define SLAVE_ADDR      7'h2a

// Register pointers
`define REG_CMD         8'h00
`define REG_RES_HI      8'h01
`define REG_RES_LO      8'h02

// Command field positions and channel count
`define CMD_GO_BIT      7
`define CMD_ATT_BIT     4
`define CMD_CH_MSB      2
`define NUM_CHANNELS    3'h6

// Status field positions
`define ST_DONE_BIT     7
`define ST_BUSY_BIT     6

// Reset values
`define CH_RST          3'h0
`define ATT_RST         1'b0
`define RES_RST         12'h000

// Timing
`define CLK_KHZ         50000
`define TOUT_MIN_MS     25
`define TOUT_CYC_DFLT   21'h1312d0

`endif

// ==== dv/adc_monitor_props.sv ====
`timescale 1ns/1ns
// --------------------
// Readout checker
// --------------------
module adc_monitor_props #(
    parameter [20:0] TOUT_CYC = 21'h0000c8
) (
    input wire       mclk,
    input wire       rst_n,
    input wire       scl_in,
    input wire       sda_oe,
    input wire [2:0] adc_sel,
    input wire       adc_atten,
    input wire       adc_start,
    input wire       scl_timeout
);
    logic [20:0] low_q;
    logic        seen_q;
    always @(posedge mclk) begin
        if (!rst_n || scl_in) begin
            low_q  <= 21'h0;
            seen_q <= 1'b0;
        end else begin
            low_q  <= low_q + 21'h1;
            seen_q <= seen_q | scl_timeout;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    sequence s_cmd;
        adc_start && adc_sel < 3'h6;
    endsequence
    sequence s_idle;
        !scl_timeout && !sda_oe;
    endsequence
    AST_START: assert property (adc_start |-> s_cmd ##1 !adc_start)
        else $error("bad conversion start");
    AST_START_LOW: assert property (adc_start |-> !scl_in)
        else $error("start outside clock low");
    AST_SELCHG: assert property (($changed(adc_sel) || $changed(adc_atten)) |-> adc_start)
        else $error("mux or attenuator moved without start");
    AST_ACK_EDGE: assert property ($rose(sda_oe) |-> !scl_in)
        else $error("data driven while clock high");
    AST_TOUT_EARLY: assert property (scl_timeout |-> low_q >= TOUT_CYC - 21'h000001)
        else $error("timeout too early");
    AST_TOUT_LATE: assert property (low_q == TOUT_CYC + 21'h000006 |-> seen_q || scl_timeout)
        else $error("timeout missing");
    AST_TOUT_IDLE: assert property (scl_timeout |=> s_idle)
        else $error("bus not released after timeout");
endmodule

// ==== dv/adc_monitor_readout_tb.sv ====
`timescale 1ns/1ns
`include "adc_mon_consts.vh"
module adc_monitor_readout_tb;
    logic       mclk;
    logic       rst_n;
    wire        scl;
    wire        h_sda;
    wire        sda;
    wire        sda_out;
    wire        sda_oe;
    wire  [2:0] adc_sel;
    wire        adc_atten;
    wire        adc_start;
    logic       adc_done = 1'b0;
    logic [9:0] adc_code = 10'h000;
    wire        scl_timeout;
    int         fail_count;
    int         checks;
    int         starts;
    int         touts;
    int         cnt = 0;
    logic [7:0] q;
    logic       ka;
    assign sda = h_sda & (sda_oe ? sda_out : 1'b1);
    adc_monitor_readout #(.TOUT_CYC(21'h0000c8)) dut (.mclk(mclk), .rst_n(rst_n),
        .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
        .adc_sel(adc_sel), .adc_atten(adc_atten), .adc_start(adc_start),
        .adc_done(adc_done), .adc_code(adc_code), .scl_timeout(scl_timeout));
    i2c_host host (.mclk(mclk), .sda_line(sda), .scl(scl), .sda_o(h_sda));
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    // --------------------
    // Converter model
    // --------------------
    always @(negedge mclk) begin
        adc_done <= 1'b0;
        if (adc_start) cnt <= 30;
        else if (cnt > 0) begin
            cnt      <= cnt - 1;
            adc_done <= (cnt == 1);
            adc_code <= 10'h3ff - {3'h0, adc_sel, 4'h0};
        end
    end
    always @(negedge mclk) begin
        starts += adc_start;
        touts  += scl_timeout;
    end
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic close_out();
        $display("Checks %0d, mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic wr(input logic [7:0] p, input logic [7:0] d);
        host.start();
        host.xfer({`SLAVE_ADDR, 1'b0}, 1'b1, q, ka);
        chk({11'h0, ka}, 12'h0);
        host.xfer(p, 1'b1, q, ka);
        host.xfer(d, 1'b1, q, ka);
        host.stop();
    endtask
    task automatic rd(input logic [7:0] p, output logic [7:0] d);
        host.start();
        host.xfer({`SLAVE_ADDR, 1'b0}, 1'b1, q, ka);
        host.xfer(p, 1'b1, q, ka);
        host.start();
        host.xfer({`SLAVE_ADDR, 1'b1}, 1'b1, q, ka);
        host.xfer(8'hff, 1'b1, d, ka);
        host.stop();
    endtask
    task automatic t_meas(input logic [2:0] ch, input logic at);
        logic [11:0] e;
        logic [7:0]  hi;
        int          n;
        e = {2'h0, 10'h3ff - {3'h0, ch, 4'h0}} * (at ? 12'h3 : 12'h1);
        wr(`REG_CMD, {1'b1, 2'h0, at, 1'b0, ch});
        chk({8'h0, adc_atten, adc_sel}, {8'h0, at, ch});
        n = 0;
        do rd(`REG_CMD, q); while (q[7] !== 1'b1 && ++n < 20);
        if (n == 20) begin
            fail_count++;
            $display("CHECK FAILED at %0t: done flag never set", $time);
            close_out();
        end
        chk({4'h0, q}, {4'h0, 3'h4, at, 1'b0, ch});
        rd(`REG_RES_HI, hi);
        rd(`REG_RES_LO, q);
        chk({hi, q[3:0]}, e);
        chk({8'h0, q[7:4]}, 12'h0);
        $display("measure ch %0d atten %0d finished", ch, at);
    endtask
    task automatic t_bad();
        int s;
        s = starts;
        wr(`REG_CMD, 8'h87);
        wr(`REG_CMD, 8'h86);
        wr(`REG_CMD, 8'h05);
        chk(12'(starts - s), 12'h0);
        $display("bad channel finished");
    endtask
    task automatic t_slow(input logic [2:0] ch, input logic at);
        logic [11:0] e;
        logic [7:0]  hi;
        e = {2'h0, 10'h3ff - {3'h0, ch, 4'h0}} * (at ? 12'h3 : 12'h1);
        wr(`REG_CMD, {1'b1, 2'h0, at, 1'b0, ch});
        host.wt(10000);
        rd(`REG_RES_HI, hi);
        rd(`REG_RES_LO, q);
        chk({hi, q[3:0]}, e);
        $display("timed read finished");
    endtask
    task automatic t_tout();
        int         t;
        logic [7:0] a;
        t = touts;
        a = {`SLAVE_ADDR, 1'b0};
        host.start();
        for (int i = 7; i >= 0; i--) host.bitx(a[i], ka);
        host.wt(2);
        chk({11'h0, sda_oe}, 12'h1);
        host.wt(230);
        chk(12'(touts - t), 12'h1);
        chk({11'h0, sda_oe}, 12'h0);
        host.stop();
        $display("clock low timeout finished");
    endtask
    initial begin
        rst_n = 1'b0;
        repeat (12) @(negedge mclk);
        rst_n = 1'b1;
        host.wt(4);
        for (int c = 0; c < 6; c++) t_meas(3'(c), c[0]);
        t_bad();
        t_tout();
        t_meas(3'h0, 1'b1);
        t_slow(3'h2, 1'b0);
        close_out();
    end
endmodule
bind adc_monitor_readout adc_monitor_props #(.TOUT_CYC(TOUT_CYC)) u_props (
    .mclk(mclk), .rst_n(rst_n), .scl_in(scl_in), .sda_oe(sda_oe), .adc_sel(adc_sel),
    .adc_atten(adc_atten), .adc_start(adc_start), .scl_timeout(scl_timeout));

// ==== dv/i2c_host.sv ====
`timescale 1ns/1ns
// --------------------
// Bus host model
// --------------------
module i2c_host (
    input  wire mclk,
    input  wire sda_line,
    output reg  scl,
    output reg  sda_o
);
    initial begin
        scl   = 1'b1; // Clock idles high between frames
        sda_o = 1'b1;
    end
    task automatic wt(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic bitx(input logic b, output logic r);
        sda_o = b;
        wt(2);
        scl = 1'b1;
        wt(2);
        r = sda_line;
        wt(2);
        scl = 1'b0; // Fixed 160 ns bit period
        wt(2);
    endtask
    task automatic start();
        sda_o = 1'b1;
        wt(4);
        scl = 1'b1;
        wt(2);
        sda_o = 1'b0; // Request any time
        wt(2);
        scl = 1'b0;
        wt(2);
    endtask
    task automatic stop();
        sda_o = 1'b0;
        wt(2);
        scl = 1'b1;
        wt(2);
        sda_o = 1'b1;
        wt(4);
    endtask
    task automatic xfer(input logic [7:0] d, input logic ak, output logic [7:0] q,
                        output logic ka);
        for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
        bitx(ak, ka);
    endtask
endmodule

// ==== rtl/adc_monitor_readout.v ====
`timescale 1ns/1ns
`include "adc_mon_consts.vh"

module adc_monitor_readout #(
    parameter [20:0] TOUT_CYC = `TOUT_CYC_DFLT
) (
    input  wire        mclk,
    input  wire        rst_n,
    input  wire        scl_in,
    input  wire        sda_in,
    output wire        sda_out,
    output reg         sda_oe,
    output reg  [2:0]  adc_sel,
    output reg         adc_atten,
    output reg         adc_start,
    input  wire        adc_done,
    input  wire [9:0]  adc_code,
    output reg         scl_timeout
);
    // ------------------------------------------------------------
    // States
    // ------------------------------------------------------------
    localparam [6:0] ST_IDLE = 7'h01;
    localparam [6:0] ST_ADDR = 7'h02;
    localparam [6:0] ST_AACK = 7'h04;
    localparam [6:0] ST_WR   = 7'h08;
    localparam [6:0] ST_WACK = 7'h10;
    localparam [6:0] ST_RD   = 7'h20;
    localparam [6:0] ST_RACK = 7'h40;

    // ------------------------------------------------------------
    // Pin synchronisers and edges
    // ------------------------------------------------------------
    wire scl_s;
    wire sda_s;
    reg  scl_q;
    reg  sda_q;

    sync2 #(.W(1)) u_scl_sync (
        .mclk  (mclk),
        .rst_n (rst_n),
        .d     (scl_in),
        .q     (scl_s)
    );

    sync2 #(.W(1)) u_sda_sync (
        .mclk  (mclk),
        .rst_n (rst_n),
        .d     (sda_in),
        .q     (sda_s)
    );

    always @(posedge mclk) begin
        if (!rst_n) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_s;
            sda_q <= sda_s;
        end
    end

    wire scl_rise = scl_s & ~scl_q;
    wire scl_fall = ~scl_s & scl_q;
    wire start_c  = scl_s & scl_q & sda_q & ~sda_s;
    wire stop_c   = scl_s & scl_q & ~sda_q & sda_s;

    assign sda_out = 1'b0;

    // ------------------------------------------------------------
    // Clock-low timeout
    // ------------------------------------------------------------
    reg [20:0] low_cnt_q;
    wire       tout_hit = (low_cnt_q == TOUT_CYC - 21'h000001) & ~scl_s;

    always @(posedge mclk) begin
        if (!rst_n) begin
            low_cnt_q   <= 21'h000000;
            scl_timeout <= 1'b0;
        end else begin
            scl_timeout <= tout_hit;
            if (scl_s)
                low_cnt_q <= 21'h000000;
            else if (low_cnt_q != TOUT_CYC)
                low_cnt_q <= low_cnt_q + 21'h000001;
        end
    end

    // ------------------------------------------------------------
    // Conversion control and result
    // ------------------------------------------------------------
    reg  [11:0] result_q;
    reg         done_q;
    reg         busy_q;
    reg         go_w;
    reg  [7:0]  cmd_w;
    wire [11:0] raw12 = {2'b00, adc_code};
    wire [11:0] x3    = raw12 + {1'b0, adc_code, 1'b0};

    always @(posedge mclk) begin
        if (!rst_n) begin
            adc_sel   <= `CH_RST;
            adc_atten <= `ATT_RST;
            adc_start <= 1'b0;
            result_q  <= `RES_RST;
            done_q    <= 1'b0;
            busy_q    <= 1'b0;
        end else begin
            adc_start <= 1'b0;
            if (go_w) begin
                adc_sel   <= cmd_w[`CMD_CH_MSB:0];
                adc_atten <= cmd_w[`CMD_ATT_BIT];
                adc_start <= 1'b1;
                busy_q    <= 1'b1;
                done_q    <= 1'b0;
            end
            if (adc_done && busy_q) begin
                result_q <= adc_atten ? x3 : raw12;
                busy_q   <= 1'b0;
                done_q   <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Serial slave
    // ------------------------------------------------------------
    reg [6:0] state_q;
    reg [3:0] bit_cnt_q;
    reg [7:0] shift_q;
    reg [7:0] ptr_q;
    reg       first_q;
    reg [7:0] rd_data;

    always @* begin
        case (ptr_q)
            `REG_CMD:    rd_data = {done_q, busy_q, 1'b0, adc_atten, 1'b0, adc_sel};
            `REG_RES_HI: rd_data = result_q[11:4];
            `REG_RES_LO: rd_data = {4'h0, result_q[3:0]};
            default:     rd_data = 8'h00;
        endcase
    end

    always @* begin
        cmd_w = shift_q;
        go_w  = (state_q == ST_WR) && scl_fall && (bit_cnt_q == 4'h8) && !first_q
                && (ptr_q == `REG_CMD) && shift_q[`CMD_GO_BIT]
                && (shift_q[`CMD_CH_MSB:0] < `NUM_CHANNELS);
    end

    always @(posedge mclk) begin
        if (!rst_n) begin
            state_q   <= ST_IDLE;
            bit_cnt_q <= 4'h0;
            shift_q   <= 8'h00;
            ptr_q     <= 8'h00;
            first_q   <= 1'b0;
            sda_oe    <= 1'b0;
        end else if (tout_hit || stop_c) begin
            state_q <= ST_IDLE;
            sda_oe  <= 1'b0;
        end else if (start_c) begin
            state_q   <= ST_ADDR;
            bit_cnt_q <= 4'h0;
            first_q   <= 1'b1;
            sda_oe    <= 1'b0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    sda_oe <= 1'b0;
                end
                ST_ADDR, ST_WR: begin
                    if (scl_rise) begin
                        shift_q   <= {shift_q[6:0], sda_s};
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end else if (scl_fall && bit_cnt_q == 4'h8) begin
                        if (state_q == ST_ADDR) begin
                            if (shift_q[7:1] == `SLAVE_ADDR) begin
                                sda_oe  <= 1'b1;
                                state_q <= shift_q[0] ? ST_RACK : ST_AACK;
                            end else begin
                                state_q <= ST_IDLE;
                            end
                        end else begin
                            sda_oe  <= 1'b1;
                            state_q <= ST_WACK;
                            if (first_q) begin
                                ptr_q   <= shift_q;
                                first_q <= 1'b0;
                            end else begin
                                ptr_q <= ptr_q + 8'h01;
                            end
                        end
                    end
                end
                ST_AACK, ST_WACK: begin
                    if (scl_fall) begin
                        sda_oe    <= 1'b0;
                        bit_cnt_q <= 4'h0;
                        state_q   <= ST_WR;
                    end
                end
                ST_RACK: begin
                    if (scl_rise && !sda_oe && sda_s) begin
                        state_q <= ST_IDLE;
                    end else if (scl_fall) begin
                        shift_q   <= rd_data;
                        sda_oe    <= ~rd_data[7];
                        bit_cnt_q <= 4'h1;
                        state_q   <= ST_RD;
                    end
                end
                ST_RD: begin
                    if (scl_fall) begin
                        if (bit_cnt_q == 4'h8) begin
                            sda_oe  <= 1'b0;
                            ptr_q   <= ptr_q + 8'h01;
                            state_q <= ST_RACK;
                        end else begin
                            shift_q   <= {shift_q[6:0], 1'b0};
                            sda_oe    <= ~shift_q[6];
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                        end
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                    sda_oe  <= 1'b0;
                end
            endcase
        end
    end
endmodule

// ==== rtl/sync2.v ====
`timescale 1ns/1ns
module sync2 #(
    parameter W = 1
) (
    input  wire         mclk,
    input  wire         rst_n,
    input  wire [W-1:0] d,
    output reg  [W-1:0] q
);
    reg [W-1:0] meta_q;

    always @(posedge mclk) begin
        if (!rst_n) begin
            meta_q <= {W{1'b1}};
            q      <= {W{1'b1}};
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule
